//--- include/chan_mode_pkg.sv
package chan_mode_pkg;

   // ----------------------------------------
   // Channel mode encodings
   // ----------------------------------------
   typedef enum logic [3:0] {
      either_match_blocking_single    = 4'h0,
      either_match_blocking_double    = 4'h1,
      either_match_nonblocking_single = 4'h2,
      either_match_nonblocking_double = 4'h3,
      match2_request_single           = 4'h4,
      match2_request_double           = 4'h5,
      both_match_single               = 4'h6,
      both_match_double               = 4'h7,
      ordered_match2_single           = 4'h8,
      ordered_match2_double           = 4'h9,
      single_match_single             = 4'hA,
      single_match_double             = 4'hB,
      single_match_enhanced           = 4'hC
   } chan_mode_e;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [3:0] MODE_RST = 4'h0;
   localparam int TB_W = 24;
   localparam logic [23:0] CAP_RST = 24'h00_0000;

   // ----------------------------------------
   // Microengine channel operations
   // ----------------------------------------
   typedef struct packed {
      logic mode_we;
      logic [3:0] mode;
      logic match1_write;
      logic match2_write;
      logic clr_match_flag_a;
      logic clr_match_flag_b;
      logic clr_transition_flag_a;
      logic clr_transition_flag_b;
      logic clr_match1_enable;
      logic clr_match2_enable;
   } ucode_op_s;

   // Channel status toward the microengine
   typedef struct packed {
      logic match_flag_a;
      logic match_flag_b;
      logic transition_flag_a;
      logic transition_flag_b;
      logic match1_enable_latch;
      logic match2_enable_latch;
   } chan_flags_s;

endpackage : chan_mode_pkg

//--- rtl/timer_channel_event_mode_logic.sv
// Contract
// - Mode held per channel, changed only by a microengine mode write.
// - Single-transition: first transition sets flag A, requests, captures both bases.
// - Single-transition: second transition sets flag B, no request, captures base 2.
// - Double-transition: second transition requests; each captures its own base.
// - Second transition armed only once transition flag A is set.
// - Match captures never overwrite transition captures, except an enhanced-mode unfiltered edge capture in capture 2.
// - Each match clears its own enable; blocking only through enables.
// - Single: first transition blocks both matches; double: second blocks match 2.
// - Either-blocking: first match blocks other, one request; simultaneous sets both.
// - Either-nonblocking: each match requests and captures independently.
// - Match2-request: transitions enabled by match 1; match 2 requests, clears enable 1.
// - Match2-request simultaneous matches: both flags set, match 2 pin action wins.
// - Both-match: no mutual blocking; request once both matches seen.
// - Both-match double: second transition blocks match 1 as well.
// - Ordered: match 2 only after match 1; match 2 requests, blocks transitions unless match 1 hits in the same cycle.
// - Single-match modes: flag B never set, match 2 enable ignored.
// - Enhanced mode captures unfiltered edge; on output acts as single-match single.
// - Either-blocking single: matches capture both bases; later transition overwrites.
// - Either-blocking double: transition A blocks match 1; B blocks match 2, requests.
// - Either-blocking double: capture 1 from transition A survives match 2.
// - Either-nonblocking single: transition sets A, blocks matches, captures, requests.
// - Transition actions only on a flag rising from 0 to 1.
// - Match value write sets its enable latch, overriding clears.
module timer_channel_event_mode_logic (
   // Clock and reset
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // Microengine operations
   input wire chan_mode_pkg::ucode_op_s ucode_op_i,
   // Raw event detections
   input wire logic match1_hit_i,
   input wire logic match2_hit_i,
   input wire logic edge1_hit_i,
   input wire logic edge2_hit_i,
   input wire logic raw_edge_hit_i,
   input wire logic output_channel_i,
   // Pin action selects and time base selectors
   input wire logic [2:0] match1_pin_action_i,
   input wire logic [2:0] match2_pin_action_i,
   input wire logic capture1_timebase_select_i,
   input wire logic capture2_timebase_select_i,
   // Time bases
   input wire logic [chan_mode_pkg::TB_W-1:0] tcr1_i,
   input wire logic [chan_mode_pkg::TB_W-1:0] tcr2_i,
   // Status and results
   output chan_mode_pkg::chan_flags_s flags_o,
   output logic [3:0] channel_mode_select_o,
   output logic [chan_mode_pkg::TB_W-1:0] capture1_o,
   output logic [chan_mode_pkg::TB_W-1:0] capture2_o,
   output logic [2:0] pin_action_o,
   output logic pin_action_valid_o,
   output logic match_request_o,
   output logic transition_request_o
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   chan_mode_pkg::chan_mode_e mode_r;
   logic mfa_r;
   logic mfb_r;
   logic tfa_r;
   logic tfb_r;
   logic me1_r;
   logic me2_r;
   logic tr_en_r;
   logic [chan_mode_pkg::TB_W-1:0] cap1_r, cap2_r;
   logic [2:0] pin_r;
   logic pin_v_r, mreq_r, treq_r;

   // ----------------------------------------
   // Mode classification
   // ----------------------------------------
   logic is_dt, is_emb, is_emnb, is_m2, is_bm, is_ord, is_sm, is_enh;
   always_comb begin
      is_dt = 1'b0;
      is_emb = 1'b0;
      is_emnb = 1'b0;
      is_m2 = 1'b0;
      is_bm = 1'b0;
      is_ord = 1'b0;
      is_sm = 1'b0;
      case (mode_r)
         chan_mode_pkg::either_match_blocking_single: begin
            is_emb = 1'b1;
         end
         chan_mode_pkg::either_match_blocking_double: begin
            is_emb = 1'b1;
            is_dt = 1'b1;
         end
         chan_mode_pkg::either_match_nonblocking_single: begin
            is_emnb = 1'b1;
         end
         chan_mode_pkg::either_match_nonblocking_double: begin
            is_emnb = 1'b1;
            is_dt = 1'b1;
         end
         chan_mode_pkg::match2_request_single: begin
            is_m2 = 1'b1;
         end
         chan_mode_pkg::match2_request_double: begin
            is_m2 = 1'b1;
            is_dt = 1'b1;
         end
         chan_mode_pkg::both_match_single: begin
            is_bm = 1'b1;
         end
         chan_mode_pkg::both_match_double: begin
            is_bm = 1'b1;
            is_dt = 1'b1;
         end
         chan_mode_pkg::ordered_match2_single: begin
            is_ord = 1'b1;
         end
         chan_mode_pkg::ordered_match2_double: begin
            is_ord = 1'b1;
            is_dt = 1'b1;
         end
         chan_mode_pkg::single_match_single: begin
            is_sm = 1'b1;
         end
         chan_mode_pkg::single_match_double: begin
            is_sm = 1'b1;
            is_dt = 1'b1;
         end
         chan_mode_pkg::single_match_enhanced: begin
            is_sm = 1'b1;
         end
      endcase
      is_enh = (mode_r == chan_mode_pkg::single_match_enhanced) && !output_channel_i;
   end

   // ----------------------------------------
   // Event qualification
   // ----------------------------------------
   logic m1_ev, m2_ev, t1_set, t2_set, t1_ev, t2_ev;
   logic tr_allowed;
   always_comb begin
      m1_ev = match1_hit_i && me1_r;
      // Ordered modes need match 1 first; single-match modes ignore match 2
      m2_ev = match2_hit_i && me2_r && !is_sm && !(is_ord && !mfa_r);
      tr_allowed = tr_en_r;
      t1_set = edge1_hit_i && tr_allowed;
      t2_set = edge2_hit_i && tr_allowed && tfa_r;
      t1_ev = t1_set && !tfa_r;
      t2_ev = t2_set && !tfb_r;
   end

   // ----------------------------------------
   // Mode write decode
   // ----------------------------------------
   logic mode_wr_ok;
   logic mode_wr_gated;
   always_comb begin
      mode_wr_ok = ucode_op_i.mode_we && (ucode_op_i.mode <= chan_mode_pkg::single_match_enhanced);
      mode_wr_gated = (ucode_op_i.mode == chan_mode_pkg::match2_request_single) ||
                      (ucode_op_i.mode == chan_mode_pkg::match2_request_double) ||
                      (ucode_op_i.mode == chan_mode_pkg::ordered_match2_single) ||
                      (ucode_op_i.mode == chan_mode_pkg::ordered_match2_double);
   end

   // ----------------------------------------
   // Mode register
   // ----------------------------------------
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         mode_r <= chan_mode_pkg::chan_mode_e'(chan_mode_pkg::MODE_RST);
      end else if (mode_wr_ok) begin
         mode_r <= chan_mode_pkg::chan_mode_e'(ucode_op_i.mode);
      end
   end

   // ----------------------------------------
   // Flags (set wins over clear)
   // ----------------------------------------
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         mfa_r <= 1'b0;
         mfb_r <= 1'b0;
         tfa_r <= 1'b0;
         tfb_r <= 1'b0;
      end else begin
         mfa_r <= m1_ev | (mfa_r & ~ucode_op_i.clr_match_flag_a);
         mfb_r <= m2_ev | (mfb_r & ~ucode_op_i.clr_match_flag_b);
         tfa_r <= t1_ev | (tfa_r & ~ucode_op_i.clr_transition_flag_a);
         tfb_r <= t2_ev | (tfb_r & ~ucode_op_i.clr_transition_flag_b);
      end
   end

   // ----------------------------------------
   // Match enable latches
   // ----------------------------------------
   logic blk1, blk2;
   always_comb begin
      blk1 = m1_ev;
      blk2 = m2_ev;
      if (is_emb) begin
         blk1 = blk1 | m2_ev;
         blk2 = blk2 | m1_ev;
      end
      if (is_m2) begin
         blk1 = blk1 | m2_ev;
      end
      if (!is_dt) begin
         blk1 = blk1 | t1_ev;
         blk2 = blk2 | t1_ev;
      end else begin
         blk2 = blk2 | t2_ev;
         if (is_bm) begin
            blk1 = blk1 | t2_ev;
         end else begin
            blk1 = blk1 | t1_ev;
         end
      end
      blk1 = blk1 | ucode_op_i.clr_match1_enable;
      blk2 = blk2 | ucode_op_i.clr_match2_enable;
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         me1_r <= 1'b0;
         me2_r <= 1'b0;
      end else begin
         me1_r <= ucode_op_i.match1_write | (me1_r & ~blk1);
         me2_r <= ucode_op_i.match2_write | (me2_r & ~blk2);
      end
   end

   // ----------------------------------------
   // Transition enable
   // ----------------------------------------
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         tr_en_r <= 1'b1;
      end else if (mode_wr_ok) begin
         tr_en_r <= !mode_wr_gated;
      end else if ((is_m2 || is_ord) && m1_ev) begin
         tr_en_r <= 1'b1;
      end else if (is_ord && m2_ev) begin
         tr_en_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // Captures
   // ----------------------------------------
   logic [chan_mode_pkg::TB_W-1:0] sel1, sel2;
   logic tc1, tc2, mc1, mc2, both_on_m;
   always_comb begin
      sel1 = capture1_timebase_select_i ? tcr2_i : tcr1_i;
      sel2 = capture2_timebase_select_i ? tcr2_i : tcr1_i;
      tc1 = 1'b0;
      tc2 = 1'b0;
      if (is_enh) begin
         tc1 = t1_ev;
         tc2 = raw_edge_hit_i && !tfa_r;
      end else if (!is_dt) begin
         tc1 = t1_ev;
         tc2 = t1_ev | t2_ev;
      end else begin
         tc1 = t1_ev;
         tc2 = t2_ev;
      end
      both_on_m = (is_emb && !is_dt) || is_sm;
      mc1 = (m1_ev || (both_on_m && m2_ev)) && !tfa_r;
      mc2 = (m2_ev || (both_on_m && m1_ev)) && !tfa_r && !tfb_r;
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         cap1_r <= chan_mode_pkg::CAP_RST;
      end else if (tc1) begin
         cap1_r <= sel1;
      end else if (mc1) begin
         cap1_r <= sel1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         cap2_r <= chan_mode_pkg::CAP_RST;
      end else if (tc2) begin
         cap2_r <= sel2;
      end else if (mc2) begin
         cap2_r <= sel2;
      end
   end

   // ----------------------------------------
   // Service requests and pin action
   // ----------------------------------------
   logic mreq, treq;
   always_comb begin
      treq = is_dt ? t2_ev : t1_ev;
      mreq = 1'b0;
      if (is_emb) begin
         mreq = (m1_ev | m2_ev) && !mfa_r && !mfb_r;
      end else if (is_emnb) begin
         mreq = m1_ev | m2_ev;
      end else if (is_m2 || is_ord) begin
         mreq = m2_ev;
      end else if (is_bm) begin
         mreq = (m1_ev | mfa_r) && (m2_ev | mfb_r) && (m1_ev | m2_ev);
      end else begin
         mreq = m1_ev;
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         mreq_r <= 1'b0;
         treq_r <= 1'b0;
      end else begin
         mreq_r <= mreq;
         treq_r <= treq;
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         pin_r <= 3'h0;
         pin_v_r <= 1'b0;
      end else begin
         pin_v_r <= m1_ev | m2_ev;
         pin_r <= m2_ev ? match2_pin_action_i : match1_pin_action_i;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   always_comb begin
      flags_o.match_flag_a = mfa_r;
      flags_o.match_flag_b = mfb_r;
      flags_o.transition_flag_a = tfa_r;
      flags_o.transition_flag_b = tfb_r;
      flags_o.match1_enable_latch = me1_r;
      flags_o.match2_enable_latch = me2_r;
   end
   assign channel_mode_select_o = mode_r;
   assign capture1_o = cap1_r;
   assign capture2_o = cap2_r;
   assign pin_action_o = pin_r;
   assign pin_action_valid_o = pin_v_r;
   assign match_request_o = mreq_r;
   assign transition_request_o = treq_r;

endmodule : timer_channel_event_mode_logic

//--- tb/chan_checker.sv
module chan_checker (
   // Clock and reset
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // Watched inputs
   input wire chan_mode_pkg::ucode_op_s ucode_op_i,
   input wire logic match1_hit_i,
   input wire logic match2_hit_i,
   input wire logic [2:0] match2_pin_action_i,
   // Watched outputs
   input wire chan_mode_pkg::chan_flags_s flags_o,
   input wire logic [3:0] channel_mode_select_o,
   input wire logic [2:0] pin_action_o,
   input wire logic pin_action_valid_o,
   input wire logic match_request_o,
   input wire logic transition_request_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   logic both_w;
   assign both_w = match1_hit_i && match2_hit_i && flags_o.match1_enable_latch && flags_o.match2_enable_latch;
   property p_mode_hold; !ucode_op_i.mode_we |=> $stable(channel_mode_select_o); endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("mode moved without write");
   property p_m1_self;
      flags_o.match1_enable_latch && match1_hit_i && !ucode_op_i.match1_write |=> !flags_o.match1_enable_latch;
   endproperty
   a_m1_self: assert property (p_m1_self) else $error("match1 enable kept");
   property p_m2_write; ucode_op_i.match2_write |=> flags_o.match2_enable_latch; endproperty
   a_m2_write: assert property (p_m2_write) else $error("match2 write lost");
   property p_flagb_order; $rose(flags_o.transition_flag_b) |-> $past(flags_o.transition_flag_a); endproperty
   a_flagb_order: assert property (p_flagb_order) else $error("flag b before a");
   property p_treq_rise;
      transition_request_o |-> $rose(flags_o.transition_flag_a) || $rose(flags_o.transition_flag_b);
   endproperty
   a_treq_rise: assert property (p_treq_rise) else $error("request without rise");
   property p_b_req;
      $rose(flags_o.transition_flag_b) |-> transition_request_o == $past(channel_mode_select_o[0]);
   endproperty
   a_b_req: assert property (p_b_req) else $error("second edge request wrong");
   property p_single_nob;
      channel_mode_select_o inside {4'hA, 4'hB, 4'hC} && !flags_o.match_flag_b |=> !flags_o.match_flag_b;
   endproperty
   a_single_nob: assert property (p_single_nob) else $error("match flag b set");
   property p_m2_pin;
      channel_mode_select_o inside {4'h4, 4'h5} && both_w |=>
         pin_action_valid_o && pin_action_o == $past(match2_pin_action_i);
   endproperty
   a_m2_pin: assert property (p_m2_pin) else $error("pin action priority");
   property p_eb_both;
      channel_mode_select_o inside {4'h0, 4'h1} && both_w && !flags_o.match_flag_a && !flags_o.match_flag_b
         |=> flags_o.match_flag_a && flags_o.match_flag_b && match_request_o;
   endproperty
   a_eb_both: assert property (p_eb_both) else $error("simultaneous match");
endmodule : chan_checker

//--- tb/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_i = 1'h0;
   logic sys_rst_i = 1'h1;
   logic go = 1'h0;
   logic [3:0] mode = 4'h0;
   logic [1:0] arm = 2'h0;
   logic m1 = 1'h0, m2 = 1'h0, e1 = 1'h0, e2 = 1'h0, s1 = 1'h0, s2 = 1'h0;
   logic raw = 1'h0, outc = 1'h0;
   logic [2:0] pa1 = 3'h0, pa2 = 3'h0, pa;
   logic [23:0] t1 = 24'h00_0000, t2 = 24'h00_0000, c1, c2;
   logic busy, pav, mreq, treq;
   logic [3:0] mo;
   chan_mode_pkg::ucode_op_s op;
   chan_mode_pkg::chan_flags_s fl;
   int errors = 0;
   int num_checks = 0;
   always #5 clock_i = ~clock_i;
   ucode_model pm_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .go_i(go), .mode_i(mode), .arm_i(arm),
      .busy_o(busy), .op_o(op));
   timer_channel_event_mode_logic dut_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .ucode_op_i(op),
      .match1_hit_i(m1), .match2_hit_i(m2), .edge1_hit_i(e1), .edge2_hit_i(e2), .raw_edge_hit_i(raw),
      .output_channel_i(outc), .match1_pin_action_i(pa1), .match2_pin_action_i(pa2),
      .capture1_timebase_select_i(s1), .capture2_timebase_select_i(s2), .tcr1_i(t1), .tcr2_i(t2),
      .flags_o(fl), .channel_mode_select_o(mo), .capture1_o(c1), .capture2_o(c2), .pin_action_o(pa),
      .pin_action_valid_o(pav), .match_request_o(mreq), .transition_request_o(treq));
   task chk(input logic [23:0] seen, input logic [23:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task conclude;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : conclude
   // Event pulse of one cycle with fresh time bases: {match1, match2, edge1, edge2}
   task ev(input logic [3:0] v);
      @(posedge clock_i);
      {m1, m2, e1, e2} <= v;
      t1 <= 24'($urandom);
      t2 <= 24'($urandom);
      @(posedge clock_i);
      {m1, m2, e1, e2} <= 4'h0;
      #1;
   endtask : ev
   task setup(input logic [3:0] md, input logic [1:0] am);
      int n;
      @(posedge clock_i);
      go <= 1'h1;
      mode <= md;
      arm <= am;
      s1 <= 1'($urandom);
      s2 <= 1'($urandom);
      pa1 <= 3'($urandom);
      pa2 <= 3'($urandom);
      @(posedge clock_i);
      go <= 1'h0;
      n = 0;
      do begin
         @(posedge clock_i);
         #1;
         n++;
      end while (busy !== 1'h0 && n < 8);
      if (n >= 8) begin
         errors++;
         conclude();
      end
   endtask : setup
   function automatic logic [23:0] tb_of(input logic s);
      return s ? t2 : t1;
   endfunction : tb_of
   // Expected {match1 request, match flag b, match2 request}
   function automatic logic [2:0] exp_m(input logic [3:0] m);
      if (m < 4'h2 || m > 4'h9) return 3'h4;
      if (m < 4'h4) return 3'h7;
      return 3'h3;
   endfunction : exp_m
   initial begin
      int k;
      logic [3:0] md;
      logic [2:0] e;
      logic [23:0] keep;
      void'($urandom(32'h0000_9572));
      repeat (19) @(posedge clock_i);
      #1;
      chk(fl, '0);
      chk(mo, 4'h0);
      chk(c1, '0);
      @(posedge clock_i);
      sys_rst_i <= 1'h0;
      for (k = 0; k < 13; k++) begin
         md = k[3:0];
         e = exp_m(md);
         setup(md, 2'h3);
         chk(mo, md);
         ev(4'h8);
         chk(mreq, e[2]);
         chk(c1, tb_of(s1));
         ev(4'h4);
         chk(fl.match_flag_b, e[1]);
         chk(mreq, e[0]);
         setup(md, 2'h3);
         ev(4'h1);
         chk(fl.transition_flag_b, 1'h0);
         if (md inside {4'h4, 4'h5, 4'h8, 4'h9}) begin
            ev(4'h2);
            chk(fl.transition_flag_a, 1'h0);
            ev(4'h8);
         end
         ev(4'h2);
         chk(treq, !md[0]);
         if (md != 4'hC) chk(c1, tb_of(s1));
         keep = c1;
         ev(4'h8);
         chk(c1, keep);
         ev(4'h2);
         chk(treq, 1'h0);
         ev(4'h1);
         chk(fl.transition_flag_b, 1'h1);
         chk(treq, md[0]);
         if (md != 4'hC) chk(c2, tb_of(s2));
         $display("mode %0d done", k);
      end
      setup(4'h0, 2'h3);
      ev(4'h4);
      chk(c1, tb_of(s1));
      chk(c2, tb_of(s2));
      setup(4'hC, 2'h3);
      @(posedge clock_i);
      raw <= 1'h1;
      t2 <= 24'($urandom);
      @(posedge clock_i);
      raw <= 1'h0;
      outc <= 1'h1;
      #1;
      chk(c2, tb_of(s2));
      ev(4'h2);
      chk(c2, tb_of(s2));
      @(posedge clock_i);
      outc <= 1'h0;
      $display("capture corner cases done");
      for (k = 0; k < 2; k++) begin
         md = k ? 4'h4 : 4'h0;
         setup(md, 2'h3);
         ev(4'hC);
         chk({fl.match_flag_a, fl.match_flag_b, mreq, pav}, 4'hF);
         if (k == 1) chk(pa, pa2);
      end
      setup(4'hF, 2'h0);
      chk(mo, 4'h4);
      $display("simultaneous and refused mode done");
      conclude();
   end
endmodule : testbench
bind timer_channel_event_mode_logic chan_checker chk_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
   .ucode_op_i(ucode_op_i), .match1_hit_i(match1_hit_i), .match2_hit_i(match2_hit_i),
   .match2_pin_action_i(match2_pin_action_i), .flags_o(flags_o), .channel_mode_select_o(channel_mode_select_o),
   .pin_action_o(pin_action_o), .pin_action_valid_o(pin_action_valid_o), .match_request_o(match_request_o),
   .transition_request_o(transition_request_o));

//--- tb/ucode_model.sv
module ucode_model (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic go_i,
   input wire logic [3:0] mode_i,
   input wire logic [1:0] arm_i,
   output logic busy_o,
   output chan_mode_pkg::ucode_op_s op_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] step_r;
   assign busy_o = (step_r != 2'h0);
   // Clear all latches, then write mode, then arm matches
   always_ff @(posedge clock_i) begin
      op_o <= '0;
      if (sys_rst_i) begin
         step_r <= 2'h0;
      end else if (step_r == 2'h0) begin
         if (go_i) begin
            step_r <= 2'h1;
            op_o[5:0] <= 6'h3F;
         end
      end else begin
         step_r <= step_r + 2'h1;
         op_o.mode_we <= (step_r == 2'h1);
         op_o.mode <= mode_i;
         op_o.match1_write <= (step_r == 2'h2) && arm_i[0];
         op_o.match2_write <= (step_r == 2'h2) && arm_i[1];
      end
   end
endmodule : ucode_model
